// ### common/scp_pkg.sv
`default_nettype none
package scp_pkg;
	localparam int NCH = 2;
	localparam int ADDR_W = 4;
	// word offsets (byte addresses)
	localparam logic [ADDR_W-1:0] ADDR_TARGET0 = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_TARGET1 = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_CALIB   = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_FAULT   = 4'hc;
	// target register: [10:0] current target, [15] enable, [23:16] period, [24] low side config
	localparam int TGT_W = 11;
	localparam int TGT_EN_BIT = 15;
	localparam int PER_LSB = 16;
	localparam int PER_W = 8;
	localparam int LS_BIT = 24;
	// calibration register: [0] mode, [5:2] drive bits, [31:16] readback
	localparam int CM_BIT = 0;
	localparam int DRV_LSB = 2;
	localparam int DRV_W = 4;
	localparam int CAL_RB_LSB = 16;
	localparam int CAL_RB_W = 16;
	// fault register per channel, 4 bits at ch*4: ovc, open_load_bypass_flag, ot, ot_active
	localparam int FLT_STRIDE = 4;
	localparam int FLT_OVC = 0;
	localparam int FLT_OPEN_LOAD_BYPASS_FLAG = 1;
	localparam int FLT_OT = 2;
	localparam int FLT_OTACT = 3;
	localparam logic [PER_W-1:0] PER_INVALID = 8'h00;
	localparam int OVERLOAD_FILTER_TIMER_CYCLES = 30;
	localparam logic [31:0] WB_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic ovl_high;   // above high threshold
		logic ovl_low;    // above low threshold
		logic ovl_drive;  // overload located in own drive fet
		logic open_on;    // open load while on
		logic overtemp;   // temperature indication
		logic sw_state;   // monitored transistor state
	} scp_sense_s;

	typedef struct packed {
		logic [TGT_W-1:0] target;
		logic             enable;
		logic [PER_W-1:0] period;
		logic             low_side_config;
	} scp_chcfg_s;
endpackage : scp_pkg
`default_nettype wire

// ### design/scp_overload_filter_timer.sv
`timescale 1ns/100ps
`default_nettype none
module scp_overload_filter_timer #(
	parameter int CYCLES = scp_pkg::OVERLOAD_FILTER_TIMER_CYCLES
) (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic armed,
	input  wire logic ovl_low,
	input  wire logic ovl_high,
	input  wire logic sw_state,
	output logic      trip
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);
	logic [CW-1:0] cnt_reg;
	logic          sw_d_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			sw_d_reg <= 1'b0;
		else
			sw_d_reg <= sw_state;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			cnt_reg <= '0;
		else if (!armed || !ovl_low || sw_state != sw_d_reg)
			cnt_reg <= '0;
		else if (cnt_reg != LAST)
			cnt_reg <= cnt_reg + CW'(1);
	end

	// high threshold trips at once; low only after the filter time
	assign trip = armed && (ovl_high || (ovl_low && cnt_reg == LAST));
endmodule : scp_overload_filter_timer
`default_nettype wire

// ### design/scp_top.sv
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - calibration entered only with both targets zero and enable set
// - mode write discarded if any channel is on
// - in calibration, drive bits switch transistors directly
// - calibration readback is 16-bit average current, full scale 1.5 A
// - readback invalid when period is zero
// - current limiting off during calibration
// - overload switches channel off, clears target and enable, latches flag
// - overcurrent flag cleared by fault register read
// - high threshold disables stage at once
// - between thresholds, fault only after filter time persists
// - own fet sets overcurrent flag, opposite fet or open load sets bypass flag
// - each channel has own overtemperature, only that channel switched off
// - overtemperature turns channel off, clears target and enable, latches flag (in calibration the drive bits still switch the fets)
// - channel stays off while overtemperature indication persists (in calibration the drive bits still switch the fets)
// - restart needs fault read, enable set and nonzero target
// - overtemperature flag held until read and condition ended
// - overcurrent filter lasts between 20 and 40 clocks
// - overcurrent protection active only when enabled with nonzero target
module scp_top #(
	parameter int OVERLOAD_FILTER_TIMER = scp_pkg::OVERLOAD_FILTER_TIMER_CYCLES
) (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [scp_pkg::ADDR_W-1:0]    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic      [31:0]                   wb_dat_o,
	output logic                               wb_ack_o,
	input  wire scp_pkg::scp_sense_s           sense_i [scp_pkg::NCH],
	input  wire logic [scp_pkg::CAL_RB_W-1:0] cal_avg_i,
	input  wire logic [scp_pkg::NCH-1:0]      reg_drive_i,
	input  wire logic [scp_pkg::NCH-1:0]      reg_recirc_i,
	output logic      [scp_pkg::NCH-1:0]      drive_fet_o,
	output logic      [scp_pkg::NCH-1:0]      recirc_fet_o,
	output logic                               calibration_mode_o,
	output logic                               limit_active_o,
	output logic                               cal_valid_o
);
	localparam int NCH = scp_pkg::NCH;

	scp_pkg::scp_chcfg_s               cfg_reg [NCH];
	logic                              calibration_mode_bit_reg;
	logic [scp_pkg::DRV_W-1:0]         transistor_drive_bits_reg;
	logic [NCH-1:0]                    ovc_reg;
	logic [NCH-1:0]                    open_load_bypass_flag_reg;
	logic [NCH-1:0]                    ot_reg;
	logic [NCH-1:0]                    trip;
	logic [NCH-1:0]                    armed;
	logic [NCH-1:0]                    ch_off;
	logic [NCH-1:0]                    ch_on;
	logic                              req;
	logic                              wr;
	logic                              rd_fault;
	logic                              cm_write_ok;
	logic [31:0]                       rdata;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd_fault = req && !wb_we_i && wb_adr_i == scp_pkg::ADDR_FAULT;

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : gen_ch
			assign ch_off[g] = cfg_reg[g].target == '0;
			// overcurrent and open-load protection only while enabled with nonzero target, never in calibration
			assign armed[g] = cfg_reg[g].enable && !ch_off[g] && !calibration_mode_bit_reg;
			assign ch_on[g] = armed[g] && !ot_reg[g] && !sense_i[g].overtemp;
			scp_overload_filter_timer #(
				.CYCLES  (OVERLOAD_FILTER_TIMER)
			) u_overload_filter_timer (
				.clk      (clk),
				.resetn   (resetn),
				.armed    (armed[g]),
				.ovl_low  (sense_i[g].ovl_low),
				.ovl_high (sense_i[g].ovl_high),
				.sw_state (sense_i[g].sw_state),
				.trip     (trip[g])
			);
		end
	endgenerate

	// mode accepted only when every channel is off and enabled
	always_comb
	begin
		cm_write_ok = 1'b1;
		for (int i = 0; i < NCH; i++)
			if (!ch_off[i] || !cfg_reg[i].enable)
				cm_write_ok = 1'b0;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			calibration_mode_bit_reg  <= 1'b0;
			transistor_drive_bits_reg <= '0;
		end
		else if (wr && wb_adr_i == scp_pkg::ADDR_CALIB)
		begin
			transistor_drive_bits_reg <= wb_dat_i[scp_pkg::DRV_LSB +: scp_pkg::DRV_W];
			if (!wb_dat_i[scp_pkg::CM_BIT])
				calibration_mode_bit_reg <= 1'b0;
			else if (cm_write_ok)
				calibration_mode_bit_reg <= 1'b1;
		end
	end

	// targets; protection clears win over a same-cycle write
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < NCH; i++)
				cfg_reg[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (wr && wb_adr_i == (i == 0 ? scp_pkg::ADDR_TARGET0 : scp_pkg::ADDR_TARGET1))
				begin
					cfg_reg[i].target <= wb_dat_i[scp_pkg::TGT_W-1:0];
					cfg_reg[i].enable <= wb_dat_i[scp_pkg::TGT_EN_BIT];
					cfg_reg[i].period <= wb_dat_i[scp_pkg::PER_LSB +: scp_pkg::PER_W];
					cfg_reg[i].low_side_config <= wb_dat_i[scp_pkg::LS_BIT];
				end
				if ((armed[i] && (trip[i] || sense_i[i].open_on)) || sense_i[i].overtemp)
				begin
					cfg_reg[i].target <= '0;
					cfg_reg[i].enable <= 1'b0;
				end
			end
		end
	end

	// fault flags: set wins over read clear
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ovc_reg  <= '0;
			open_load_bypass_flag_reg <= '0;
			ot_reg   <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				if (armed[i] && (trip[i] && !sense_i[i].ovl_drive || sense_i[i].open_on))
					open_load_bypass_flag_reg[i] <= 1'b1;
				else if (rd_fault)
					open_load_bypass_flag_reg[i] <= 1'b0;
				if (armed[i] && trip[i] && sense_i[i].ovl_drive)
					ovc_reg[i] <= 1'b1;
				else if (rd_fault)
					ovc_reg[i] <= 1'b0;
				if (sense_i[i].overtemp)
					ot_reg[i] <= 1'b1;
				else if (rd_fault)
					ot_reg[i] <= 1'b0;
			end
		end
	end

	always_comb
	begin
		rdata = scp_pkg::WB_ZERO;
		case (wb_adr_i)
			scp_pkg::ADDR_TARGET0, scp_pkg::ADDR_TARGET1:
			begin
				for (int i = 0; i < NCH; i++)
					if (wb_adr_i == (i == 0 ? scp_pkg::ADDR_TARGET0 : scp_pkg::ADDR_TARGET1))
					begin
						rdata[scp_pkg::TGT_W-1:0] = cfg_reg[i].target;
						rdata[scp_pkg::TGT_EN_BIT] = cfg_reg[i].enable;
						rdata[scp_pkg::PER_LSB +: scp_pkg::PER_W] = cfg_reg[i].period;
						rdata[scp_pkg::LS_BIT] = cfg_reg[i].low_side_config;
					end
			end
			scp_pkg::ADDR_CALIB:
			begin
				rdata[scp_pkg::CM_BIT] = calibration_mode_bit_reg;
				rdata[scp_pkg::DRV_LSB +: scp_pkg::DRV_W] = transistor_drive_bits_reg;
				if (calibration_mode_bit_reg)
					rdata[scp_pkg::CAL_RB_LSB +: scp_pkg::CAL_RB_W] = cal_avg_i;
			end
			scp_pkg::ADDR_FAULT:
			begin
				for (int i = 0; i < NCH; i++)
				begin
					rdata[i*scp_pkg::FLT_STRIDE + scp_pkg::FLT_OVC] = ovc_reg[i];
					rdata[i*scp_pkg::FLT_STRIDE + scp_pkg::FLT_OPEN_LOAD_BYPASS_FLAG] = open_load_bypass_flag_reg[i];
					rdata[i*scp_pkg::FLT_STRIDE + scp_pkg::FLT_OT] = ot_reg[i];
					rdata[i*scp_pkg::FLT_STRIDE + scp_pkg::FLT_OTACT] = sense_i[i].overtemp;
				end
			end
			default:
				rdata = scp_pkg::WB_ZERO;
		endcase
	end

	// single wait-free answer: ack one cycle after request seen
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= req ? rdata : scp_pkg::WB_ZERO;
		end
	end

	// output stage: calibration drives fets straight from the drive bits
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			drive_fet_o  <= '0;
			recirc_fet_o <= '0;
		end
		else if (calibration_mode_bit_reg)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				drive_fet_o[i]  <= transistor_drive_bits_reg[2*i];
				recirc_fet_o[i] <= transistor_drive_bits_reg[2*i+1];
			end
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				// fast path: a trip this cycle drops the stage at once
				drive_fet_o[i]  <= ch_on[i] && !trip[i] && reg_drive_i[i];
				recirc_fet_o[i] <= ch_on[i] && !trip[i] && reg_recirc_i[i];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			calibration_mode_o <= 1'b0;
			limit_active_o     <= 1'b0;
			cal_valid_o        <= 1'b0;
		end
		else
		begin
			calibration_mode_o <= calibration_mode_bit_reg;
			limit_active_o     <= !calibration_mode_bit_reg;
			// period of channel 0 governs the calibration measurement
			cal_valid_o <= calibration_mode_bit_reg && cfg_reg[0].period != scp_pkg::PER_INVALID;
		end
	end
endmodule : scp_top
`default_nettype wire

// ### verif/scp_plant.sv
`timescale 1ns/100ps
`default_nettype none
module scp_plant #(
	parameter logic [15:0] CAL = 16'h4d2c // arbitrary measurement value
) (
	input  wire logic [scp_pkg::NCH-1:0]  drive_fet_o,
	input  wire logic [scp_pkg::NCH-1:0]  toggle,
	input  wire scp_pkg::scp_sense_s      req [scp_pkg::NCH],
	output var scp_pkg::scp_sense_s       sense [scp_pkg::NCH],
	output logic [15:0]                   cal_avg
);
	assign cal_avg = CAL;
	// monitored transistor follows its gate; toggle forces a state change mid-filter
	always_comb
	begin
		for (int i = 0; i < scp_pkg::NCH; i++)
		begin
			sense[i] = req[i];
			sense[i].sw_state = drive_fet_o[i] ^ toggle[i];
		end
	end
endmodule : scp_plant
`default_nettype wire

// ### verif/scp_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module scp_top_assertions #(
	parameter int OVERLOAD_FILTER_TIMER = scp_pkg::OVERLOAD_FILTER_TIMER_CYCLES
) (
	input wire logic                         clk,
	input wire logic                         resetn,
	input wire logic                         wb_cyc_i,
	input wire logic                         wb_stb_i,
	input wire logic                         wb_we_i,
	input wire logic [scp_pkg::ADDR_W-1:0]   wb_adr_i,
	input wire logic [31:0]                  wb_dat_o,
	input wire logic                         wb_ack_o,
	input wire scp_pkg::scp_sense_s          sense_i [scp_pkg::NCH],
	input wire logic [scp_pkg::CAL_RB_W-1:0] cal_avg_i,
	input wire logic [scp_pkg::NCH-1:0]      drive_fet_o,
	input wire logic                         calibration_mode_o,
	input wire logic                         limit_active_o
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_cal_rd;
		calibration_mode_o && wb_ack_o && !wb_we_i && wb_adr_i == scp_pkg::ADDR_CALIB;
	endsequence
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == scp_pkg::WB_ZERO; endproperty
	property p_cal_rb; s_cal_rd |-> wb_dat_o[31:16] == cal_avg_i; endproperty
	property p_no_limit; calibration_mode_o [*2] |-> !limit_active_o; endproperty
	property p_cal_enter; $rose(calibration_mode_o) |-> $past(drive_fet_o) == 2'b00; endproperty
	property p_hi_trip; sense_i[0].ovl_high && drive_fet_o[0] && !calibration_mode_o |=> !drive_fet_o[0]; endproperty
	property p_ot_off; sense_i[0].overtemp && !calibration_mode_o |=> drive_fet_o[0] == 1'b0; endproperty
	property p_filter;
		$rose(sense_i[0].ovl_low) && !sense_i[0].ovl_high && !sense_i[0].overtemp && !sense_i[0].open_on
			&& drive_fet_o[0] |=> drive_fet_o[0];
	endproperty
	a_ack: assert property (p_ack) else $error("no ack one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero outside ack");
	a_cal_rb: assert property (p_cal_rb) else $error("calibration readback wrong");
	a_no_limit: assert property (p_no_limit) else $error("limiting active in calibration");
	a_cal_enter: assert property (p_cal_enter) else $error("calibration entered with channel on");
	a_hi_trip: assert property (p_hi_trip) else $error("high overload did not switch off");
	a_ot_off: assert property (p_ot_off) else $error("overheated channel still on");
	a_filter: assert property (p_filter) else $error("low overload tripped without filter");
endmodule : scp_top_assertions
bind scp_top scp_top_assertions #(.OVERLOAD_FILTER_TIMER(OVERLOAD_FILTER_TIMER)) chk_u (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.sense_i(sense_i), .cal_avg_i(cal_avg_i), .drive_fet_o(drive_fet_o),
	.calibration_mode_o(calibration_mode_o), .limit_active_o(limit_active_o));
`default_nettype wire

// ### verif/solenoid_channel_protect_calib_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module solenoid_channel_protect_calib_tb;
	localparam int TF = 4;
	localparam logic [31:0] EN = 32'h1 << scp_pkg::TGT_EN_BIT;
	localparam logic [31:0] ON = EN | 32'h0000_0005;
	localparam logic [3:0] T0 = scp_pkg::ADDR_TARGET0;
	localparam logic [3:0] FT = scp_pkg::ADDR_FAULT;
	logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, cm, lim, cv;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, q;
	logic [1:0] fet, rfet, tgl, rdrv = 2'b11, rrec = 2'b00;
	logic [15:0] cal;
	scp_pkg::scp_sense_s sreq [scp_pkg::NCH];
	scp_pkg::scp_sense_s sense [scp_pkg::NCH];
	int fails = 0, cmp_count = 0;
	scp_plant plant_u (.drive_fet_o(fet), .toggle(tgl), .req(sreq), .sense(sense), .cal_avg(cal));
	scp_top #(.OVERLOAD_FILTER_TIMER(TF)) dut_u (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sense_i(sense),
		.cal_avg_i(cal), .reg_drive_i(rdrv), .reg_recirc_i(rrec), .drive_fet_o(fet), .recirc_fet_o(rfet),
		.calibration_mode_o(cm), .limit_active_o(lim), .cal_valid_o(cv));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task automatic results();
		$display("compares=%0d fails=%0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	// ends two negedges after release so two-stage registered outputs have settled
	task automatic wb_io(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
		// ack and read data are taken at the rising edge, then the request is dropped
		do @(posedge clk); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
		repeat (2) @(negedge clk);
	endtask : wb_io
	initial
	begin
		#100000;
		fails++;
		results();
	end
	initial
	begin
		sreq[0] = '0;
		sreq[1] = '0;
		tgl = 2'b00;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		wb_io(0, 4'h2, 0);
		`CHK(q, 32'h0)
		wb_io(1, T0, ON);
		wb_io(1, scp_pkg::ADDR_CALIB, 32'h1);
		wb_io(0, scp_pkg::ADDR_CALIB, 0);
		`CHK(q[0], 1'b0)
		wb_io(1, T0, EN | 32'h0010_0000);
		wb_io(1, scp_pkg::ADDR_TARGET1, EN);
		wb_io(1, scp_pkg::ADDR_CALIB, 32'hd);
		`CHK({cm, fet, rfet, lim, cv}, 7'b1010101)
		wb_io(0, scp_pkg::ADDR_CALIB, 0);
		`CHK(q[31:16], cal)
		wb_io(1, T0, EN);
		`CHK(cv, 1'b0)
		wb_io(1, scp_pkg::ADDR_CALIB, 0);
		`CHK({cm, fet, rfet, lim}, 6'b000001)
		for (int d = 0; d < 2; d++)
		begin
			wb_io(1, T0, ON);
			wb_io(0, FT, 0);
			`CHK(fet[0], 1'b1)
			@(posedge clk);
			sreq[0].ovl_high <= 1'b1;
			sreq[0].ovl_drive <= d[0];
			@(posedge clk);
			sreq[0].ovl_high <= 1'b0;
			wb_io(0, T0, 0);
			`CHK({q[15:0], fet[0]}, 17'h0)
			wb_io(0, FT, 0);
			`CHK(q[1:0], d ? 2'b01 : 2'b10)
			wb_io(0, FT, 0);
			`CHK(q[1:0], 2'b00)
		end
		wb_io(1, T0, ON);
		@(posedge clk);
		sreq[0].ovl_low <= 1'b1;
		repeat (TF - 2) @(posedge clk);
		tgl <= 2'b01;
		// without the restart the filter would already have tripped by now
		repeat (TF) @(posedge clk);
		@(negedge clk);
		`CHK(fet[0], 1'b1)
		repeat (2 * TF) @(negedge clk);
		`CHK(fet[0], 1'b0)
		@(posedge clk);
		sreq[0].ovl_low <= 1'b0;
		wb_io(0, FT, 0);
		`CHK(q[0], 1'b1)
		wb_io(1, T0, ON);
		wb_io(1, scp_pkg::ADDR_TARGET1, ON);
		@(posedge clk);
		sreq[0].overtemp <= 1'b1;
		wb_io(0, FT, 0);
		`CHK({q[7:0], fet}, 10'h032)
		wb_io(1, T0, ON);
		wb_io(0, FT, 0);
		`CHK({q[2], fet[0]}, 2'b10)
		@(posedge clk);
		sreq[0].overtemp <= 1'b0;
		wb_io(0, FT, 0);
		`CHK(q[3:2], 2'b01)
		wb_io(0, FT, 0);
		`CHK(q[2], 1'b0)
		wb_io(1, T0, ON);
		`CHK(fet[0], 1'b1)
		@(posedge clk);
		{rdrv, rrec} <= {2'b10, 2'b01};
		repeat (2) @(negedge clk);
		`CHK({fet, rfet}, 4'b1001)
		results();
	end
endmodule : solenoid_channel_protect_calib_tb
`default_nettype wire
